/* design/i2st_regs.svh */
`ifndef I2ST_REGS_SVH
`define I2ST_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define I2ST_IDX_DATA 8'he0
`define I2ST_IDX_STATE 8'hed
`define I2ST_IDX_RATE 8'hee
`define I2ST_IDX_TIMEOUT 8'hef
`define I2ST_IDX_CTRL 8'hea
`define I2ST_IDX_INTSTAT 8'heb
`define I2ST_IDX_INTMASK 8'hec

// Timeout control fields.
`define I2ST_TO_RUN 2
`define I2ST_TO_PRESC 1
`define I2ST_TO_FLAG 0

// Control fields.
`define I2ST_CTRL_SI 0
`define I2ST_CTRL_SIE 1
`define I2ST_CTRL_GIE 2

// Interrupt status and mask fields.
`define I2ST_INT_EVENT 0
`define I2ST_INT_TIMEOUT 1
`define I2ST_INT_BUSERR 2

// State codes, reset values and the last prescaler count.
`define I2ST_CODE_IDLE 5'h1f
`define I2ST_CODE_BUSERR 5'h00
`define I2ST_STATE_RST 8'hf8
`define I2ST_DATA_RST 8'h00
`define I2ST_RATE_RST 8'h00
`define I2ST_MASK_RST 3'h7
`define I2ST_PRESC_LAST 2'h3

`endif

/* design/i2st_pkg.sv */
package i2st_pkg;

    // Signals from the shift engine of the serial controller.
    typedef struct packed {
        logic stateStrobe;
        logic [4:0] stateCode;
        logic rxLoad;
        logic [7:0] rxByte;
        logic byteActive;
    } i2st_eng_in_t;

    // Signals back to the shift engine.
    typedef struct packed {
        logic serialEvent;
        logic bitTick;
        logic [7:0] txByte;
    } i2st_eng_out_t;

    // Interrupt sources held in the sticky status register.
    typedef struct packed {
        logic busErr;
        logic timeout;
        logic event_;
    } i2st_int_t;

endpackage : i2st_pkg

/* design/i2st_top.sv */
// Functional notes
// - State code low three bits read zero.
// - Upper five bits hold protocol state code.
// - Idle code F8 raises no flag.
// - Entering non-idle state sets flag, interrupt.
// - Code valid after flag, held past clear.
// - Misplaced START or STOP gives code 00.
// - Eight-bit data register, transmit or receive.
// - Bit rate derived from divider register.
// - Setting run clears then starts counter.
// - Clearing run stops the timeout counter.
// - Run set accepted only while flag clear.
// - Prescale bit selects clock or quarter.
// - Overflow sets timeout flag, requests interrupt.
// - Timeout flag cleared only by software.
// - Flag sticky; interrupt needs both enables.
module i2st_top #(
    parameter int CNT_W = 14
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire i2st_pkg::i2st_eng_in_t engIn,
    output i2st_pkg::i2st_eng_out_t engOut,
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic irq
);

`include "i2st_regs.svh"

    if (CNT_W < 3 || CNT_W > 24) begin : gBadWidth
        $error("CNT_W must lie between 3 and 24");
    end

    logic [7:0] dataReg;
    logic [7:0] dataNext;
    logic [7:0] stateReg;
    logic [7:0] stateNext;
    logic [7:0] rateReg;
    logic [7:0] divCnt_reg;
    logic [7:0] divCnt_next;
    logic [4:0] codeLatch_reg;
    logic [4:0] codeLatch_next;
    logic siReg;
    logic siNext;
    logic siDly_reg;
    logic sieReg;
    logic gieReg;
    logic runReg;
    logic runNext;
    logic prescReg;
    logic tifReg;
    logic tifNext;
    logic [CNT_W-1:0] toCount_reg;
    logic [CNT_W-1:0] toCount_next;
    logic [1:0] preCnt_reg;
    logic [1:0] preCnt_next;
    logic [2:0] intStat_reg;
    logic [2:0] intStat_next;
    logic [2:0] intMask_reg;
    logic [31:0] rdata_reg;
    logic [1:0] sclSync_reg;
    logic [1:0] sdaSync_reg;
    logic sdaLast_reg;

    // Bus decode.
    wire logic [7:0] regIdx = paddr[9:2];
    wire logic addrOk = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    wire logic hitData = addrOk && (regIdx == `I2ST_IDX_DATA);
    wire logic hitState = addrOk && (regIdx == `I2ST_IDX_STATE);
    wire logic hitRate = addrOk && (regIdx == `I2ST_IDX_RATE);
    wire logic hitTimeout = addrOk && (regIdx == `I2ST_IDX_TIMEOUT);
    wire logic hitCtrl = addrOk && (regIdx == `I2ST_IDX_CTRL);
    wire logic hitIntStat = addrOk && (regIdx == `I2ST_IDX_INTSTAT);
    wire logic hitIntMask = addrOk && (regIdx == `I2ST_IDX_INTMASK);
    wire logic hitAny = hitData | hitState | hitRate | hitTimeout | hitCtrl
        | hitIntStat | hitIntMask;
    wire logic wrAcc = psel && penable && pwrite && hitAny;
    wire logic setupRd = psel && !penable && !pwrite;
    wire logic wrData = wrAcc && hitData;
    wire logic wrRate = wrAcc && hitRate;
    wire logic wrTimeout = wrAcc && hitTimeout;
    wire logic wrCtrl = wrAcc && hitCtrl;
    wire logic wrIntStat = wrAcc && hitIntStat;
    wire logic wrIntMask = wrAcc && hitIntMask;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hitAny;
    assign prdata = rdata_reg;

    wire logic [7:0] timeoutView = {5'h00, runReg, prescReg, tifReg};
    wire logic [7:0] ctrlView = {5'h00, gieReg, sieReg, siReg};
    wire logic [7:0] readMux =
        hitData ? dataReg :
        hitState ? stateReg :
        hitRate ? rateReg :
        hitTimeout ? timeoutView :
        hitCtrl ? ctrlView :
        hitIntStat ? {5'h00, intStat_reg} :
        hitIntMask ? {5'h00, intMask_reg} : 8'h00;

    // Bus error: START or STOP seen while a byte or acknowledge is moving.
    wire logic sclHigh = sclSync_reg[1];
    wire logic sdaNow = sdaSync_reg[1];
    wire logic startCond = sclHigh && sdaLast_reg && !sdaNow;
    wire logic stopCond = sclHigh && !sdaLast_reg && sdaNow;
    wire logic busErr = engIn.byteActive && (startCond || stopCond);

    // A new state arrives; the bus error code overrides the engine's code.
    wire logic [4:0] newCode = busErr ? `I2ST_CODE_BUSERR : engIn.stateCode;
    wire logic newState = busErr || engIn.stateStrobe;
    wire logic takeEvent = newState && !siReg
        && (newCode != `I2ST_CODE_IDLE);
    wire logic siClear = wrCtrl && !pwdata[`I2ST_CTRL_SI];

    always_comb begin
        siNext = siReg;
        codeLatch_next = codeLatch_reg;
        if (siClear) begin
            siNext = 1'b0;
        end
        if (takeEvent) begin
            siNext = 1'b1;
            codeLatch_next = newCode;
        end
    end

    // The visible code follows the flag by one cycle and outlives its clear by one.
    always_comb begin
        stateNext = stateReg;
        if (siReg && !siDly_reg) begin
            stateNext = {codeLatch_reg, 3'h0};
        end else if (!siReg && siDly_reg) begin
            stateNext = `I2ST_STATE_RST;
        end
    end

    // Received byte wins over a software write in the same cycle.
    always_comb begin
        dataNext = dataReg;
        if (engIn.rxLoad) begin
            dataNext = engIn.rxByte;
        end else if (wrData) begin
            dataNext = pwdata[7:0];
        end
    end

    // Bit-rate tick: one pulse every divider+1 cycles.
    wire logic bitTick = (divCnt_reg >= rateReg);
    assign divCnt_next = bitTick ? 8'h00 : divCnt_reg + 8'h01;

    // Timeout counter.
    wire logic runAsk = wrTimeout && pwdata[`I2ST_TO_RUN];
    wire logic runStart = runAsk && !runReg && !siReg;
    wire logic countTick = !prescReg || (preCnt_reg == `I2ST_PRESC_LAST);
    wire logic cntFull = (toCount_reg == {CNT_W{1'b1}});
    wire logic overflow = runReg && !runStart && countTick && cntFull;

    always_comb begin
        runNext = runReg;
        if (wrTimeout) begin
            runNext = runStart || (runReg && pwdata[`I2ST_TO_RUN]);
        end
    end

    always_comb begin
        toCount_next = toCount_reg;
        preCnt_next = preCnt_reg + 2'h1;
        if (runStart) begin
            toCount_next = '0;
            preCnt_next = 2'h0;
        end else if (runReg && countTick) begin
            toCount_next = toCount_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_comb begin
        tifNext = tifReg;
        if (wrTimeout && !pwdata[`I2ST_TO_FLAG]) begin
            tifNext = 1'b0;
        end
        if (overflow) begin
            tifNext = 1'b1;
        end
    end

    // Sticky interrupt status: write one to clear, a new event wins.
    wire logic [2:0] intEvents = {busErr && takeEvent, overflow, takeEvent};
    always_comb begin
        intStat_next = intStat_reg;
        if (wrIntStat) begin
            intStat_next = intStat_reg & ~pwdata[2:0];
        end
        intStat_next = intStat_next | intEvents;
    end

    // Serial flag and timeout flag both require the two enables.
    wire logic flagPending = siReg || tifReg;
    assign irq = gieReg && sieReg && flagPending
        && |(intStat_reg & intMask_reg);

    assign engOut.serialEvent = siReg;
    assign engOut.bitTick = bitTick;
    assign engOut.txByte = dataReg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            sdaLast_reg <= 1'b1;
        end else begin
            sclSync_reg <= {sclSync_reg[0], sclPin};
            sdaSync_reg <= {sdaSync_reg[0], sdaPin};
            sdaLast_reg <= sdaSync_reg[1];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            siReg <= 1'b0;
            siDly_reg <= 1'b0;
            codeLatch_reg <= `I2ST_CODE_IDLE;
            stateReg <= `I2ST_STATE_RST;
            dataReg <= `I2ST_DATA_RST;
        end else begin
            siReg <= siNext;
            siDly_reg <= siReg;
            codeLatch_reg <= codeLatch_next;
            stateReg <= stateNext;
            dataReg <= dataNext;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rateReg <= `I2ST_RATE_RST;
            divCnt_reg <= 8'h00;
            sieReg <= 1'b0;
            gieReg <= 1'b0;
        end else begin
            rateReg <= wrRate ? pwdata[7:0] : rateReg;
            divCnt_reg <= divCnt_next;
            sieReg <= wrCtrl ? pwdata[`I2ST_CTRL_SIE] : sieReg;
            gieReg <= wrCtrl ? pwdata[`I2ST_CTRL_GIE] : gieReg;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            runReg <= 1'b0;
            prescReg <= 1'b0;
            tifReg <= 1'b0;
            toCount_reg <= '0;
            preCnt_reg <= 2'h0;
        end else begin
            runReg <= runNext;
            prescReg <= wrTimeout ? pwdata[`I2ST_TO_PRESC] : prescReg;
            tifReg <= tifNext;
            toCount_reg <= toCount_next;
            preCnt_reg <= preCnt_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            intStat_reg <= 3'h0;
            intMask_reg <= `I2ST_MASK_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            intStat_reg <= intStat_next;
            intMask_reg <= wrIntMask ? pwdata[2:0] : intMask_reg;
            rdata_reg <= setupRd ? {24'h00_0000, readMux} : rdata_reg;
        end
    end

    // Checks.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence flagRises;
        $rose(siReg);
    endsequence

    sequence codeShown(logic [4:0] c);
        stateReg[7:3] == c;
    endsequence

    low_bits_zero_a: assert property (stateReg[2:0] == 3'h0)
        else $error("state code low bits not zero");

    idle_no_flag_a: assert property (
        (newState && newCode == `I2ST_CODE_IDLE && !siReg) |=> !siReg)
        else $error("idle code raised the serial flag");

    event_sets_flag_a: assert property (
        (newState && newCode != `I2ST_CODE_IDLE && !siReg) |=> siReg ##1 codeShown($past(newCode, 2)))
        else $error("new state did not set flag and code");

    code_after_flag_a: assert property (
        flagRises |=> codeShown($past(codeLatch_reg)))
        else $error("code not valid one cycle after flag");

    code_holds_a: assert property (
        (siReg && siDly_reg && $past(siDly_reg)) |-> $stable(stateReg))
        else $error("state code changed while flag set");

    bus_error_code_a: assert property (
        (busErr && !siReg) |=> siReg ##1 (stateReg == 8'h00))
        else $error("bus error not reported as code 00");

    buserr_stat_a: assert property (
        (busErr && !siReg) |=> intStat_reg[`I2ST_INT_BUSERR])
        else $error("bus error not recorded in status");

    rx_byte_a: assert property (
        engIn.rxLoad |=> dataReg == $past(engIn.rxByte))
        else $error("received byte not stored");

    data_write_a: assert property (
        (wrData && !engIn.rxLoad) |=> dataReg == $past(pwdata[7:0]))
        else $error("software write to data register lost");

    // The rate must stay put for the whole period that is being checked.
    rate_tick_a: assert property (
        (bitTick && rateReg == 8'h02 && !wrRate) ##1 (!wrRate)[*2]
            |-> (!$past(bitTick) && !bitTick) ##1 bitTick)
        else $error("bit tick spacing wrong");

    timeout_start_a: assert property (
        $rose(runReg) |-> toCount_reg == '0)
        else $error("counter not cleared on start");

    timeout_stop_a: assert property ((!runReg && !runStart) |=> $stable(toCount_reg))
        else $error("counter moved while stopped");

    run_stop_a: assert property (
        (wrTimeout && !pwdata[`I2ST_TO_RUN]) |=> !runReg)
        else $error("clearing run left counter enabled");

    run_blocked_a: assert property (
        (runAsk && siReg && !runReg) |=> !runReg)
        else $error("run accepted while flag set");

    fast_count_a: assert property (
        (runReg && !prescReg && !wrTimeout) |=> toCount_reg == CNT_W'($past(toCount_reg) + 1))
        else $error("counter not stepping every cycle");

    slow_count_a: assert property (
        (runReg && prescReg && !wrTimeout && preCnt_reg == 2'h0) |=> $stable(toCount_reg))
        else $error("divided counter stepped early");

    overflow_flag_a: assert property (
        (runReg && cntFull && countTick && !wrTimeout) |=> tifReg && toCount_reg == '0)
        else $error("overflow did not set flag");

    flag_sticky_a: assert property (
        (tifReg && !(wrTimeout && !pwdata[`I2ST_TO_FLAG])) |=> tifReg)
        else $error("timeout flag cleared by hardware");

    irq_gate_a: assert property (irq |-> gieReg && sieReg && flagPending)
        else $error("interrupt without both enables");

    irq_raise_a: assert property (
        (gieReg && sieReg && tifReg && intStat_reg[`I2ST_INT_TIMEOUT]
            && intMask_reg[`I2ST_INT_TIMEOUT]) |-> irq)
        else $error("timeout flag did not request interrupt");

endmodule : i2st_top

/* bench/i2st_bus_model.sv */
module i2st_bus_model (
    input wire logic clk,
    input wire logic makeStart,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both lines rest at the pull-up level; on request a START and then a STOP appear.
    initial begin
        scl = 1'h1;
        sda = 1'h1;
        forever begin
            @(posedge clk);
            if (makeStart) begin
                sda <= 1'h0;
                repeat (4) @(posedge clk);
                sda <= 1'h1;
            end
        end
    end
endmodule : i2st_bus_model

/* bench/i2st_top_test.sv */
`include "i2st_regs.svh"
module i2st_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CW = 4;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    i2st_pkg::i2st_eng_in_t engIn = '0;
    i2st_pkg::i2st_eng_out_t engOut;
    logic sclPin;
    logic sdaPin;
    logic irq;
    logic makeStart = 1'h0;
    logic [31:0] rd;
    logic slvErr;
    int err_count = 0;
    int check_count = 0;
    always #50 clk = ~clk;
    i2st_top #(.CNT_W(CW)) i_i2st_top (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .engIn(engIn), .engOut(engOut), .sclPin(sclPin),
        .sdaPin(sdaPin), .irq(irq)
    );
    i2st_bus_model i_i2st_bus_model (
        .clk(clk), .makeStart(makeStart), .scl(sclPin), .sda(sdaPin)
    );
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb
    task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0);
        check(name, rd, exp);
    endtask : rchk
    task automatic post(input logic [4:0] code);
        engIn.stateCode <= code;
        engIn.stateStrobe <= 1'h1;
        @(posedge clk);
        engIn.stateStrobe <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : post
    task automatic clear_all;
        apb(1'h1, `I2ST_IDX_CTRL, 32'h6);
        apb(1'h1, `I2ST_IDX_INTSTAT, 32'h7);
    endtask : clear_all
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #3000000;
        err_count++;
        report_and_stop();
    end
    initial begin
        int i;
        int n;
        int ex;
        logic [7:0] v;
        void'($urandom(66));
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        rchk("state_rst", `I2ST_IDX_STATE, 32'hf8);
        rchk("data_rst", `I2ST_IDX_DATA, 32'h0);
        rchk("mask_rst", `I2ST_IDX_INTMASK, 32'h7);
        check("irq_rst", 32'(irq), 32'h0);
        apb(1'h0, 8'h00, 32'h0);
        check("unmapped_err", 32'(slvErr), 32'h1);
        check("unmapped_rd", rd, 32'h0);
        apb(1'h1, `I2ST_IDX_CTRL, 32'h6);
        for (i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h00 : 8'(($urandom % 30) + 1);
            post(v[4:0]);
            check("flag", 32'(engOut.serialEvent), 32'h1);
            check("irq_on", 32'(irq), 32'h1);
            rchk("code", `I2ST_IDX_STATE, {24'h0, v[4:0], 3'h0});
            post(~v[4:0]);
            rchk("held", `I2ST_IDX_STATE, {24'h0, v[4:0], 3'h0});
            clear_all();
            rchk("idle", `I2ST_IDX_STATE, 32'hf8);
            check("irq_off", 32'(irq), 32'h0);
        end
        post(5'h1f);
        check("idle_noflag", 32'(engOut.serialEvent), 32'h0);
        post(5'h08);
        for (i = 0; i < 4; i++) begin
            apb(1'h1, `I2ST_IDX_CTRL, {29'h0, i[1:0], 1'h1});
            check("irq_en", 32'(irq), 32'(i == 3));
        end
        apb(1'h1, `I2ST_IDX_INTMASK, 32'h6);
        check("irq_mask", 32'(irq), 32'h0);
        apb(1'h1, `I2ST_IDX_INTMASK, 32'h7);
        clear_all();
        v = 8'($urandom);
        apb(1'h1, `I2ST_IDX_DATA, {24'h0, v});
        check("tx", 32'(engOut.txByte), 32'(v));
        engIn.rxByte <= ~v;
        engIn.rxLoad <= 1'h1;
        @(posedge clk);
        engIn.rxLoad <= 1'h0;
        rchk("rx", `I2ST_IDX_DATA, {24'h0, ~v});
        for (i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h02 : 8'($urandom % 8);
            apb(1'h1, `I2ST_IDX_RATE, {24'h0, v});
            n = 0;
            while (engOut.bitTick !== 1'h1) @(posedge clk);
            do begin
                @(posedge clk);
                n++;
            end while (engOut.bitTick !== 1'h1);
            check("tick_period", 32'(n), 32'(v) + 32'h1);
        end
        post(5'h08);
        apb(1'h1, `I2ST_IDX_TIMEOUT, 32'h4);
        rchk("run_refused", `I2ST_IDX_TIMEOUT, 32'h0);
        clear_all();
        for (i = 0; i < 2; i++) begin
            apb(1'h1, `I2ST_IDX_TIMEOUT, (i == 1) ? 32'h6 : 32'h4);
            ex = (1 << CW) * ((i == 1) ? 4 : 1);
            n = 0;
            while (irq !== 1'h1 && n < 300) begin
                @(posedge clk);
                n++;
            end
            check("to_time", 32'(n >= ex - 5 && n <= ex + 3), 32'h1);
            repeat (20) @(posedge clk);
            apb(1'h0, `I2ST_IDX_TIMEOUT, 32'h0);
            check("to_sticky", 32'(rd[0]), 32'h1);
            apb(1'h1, `I2ST_IDX_TIMEOUT, 32'h0);
            clear_all();
            rchk("to_clear", `I2ST_IDX_TIMEOUT, 32'h0);
        end
        apb(1'h1, `I2ST_IDX_TIMEOUT, 32'h4);
        repeat (5) @(posedge clk);
        apb(1'h1, `I2ST_IDX_TIMEOUT, 32'h1);
        repeat (40) @(posedge clk);
        rchk("to_stopped", `I2ST_IDX_TIMEOUT, 32'h0);
        check("to_noirq", 32'(irq), 32'h0);
        apb(1'h1, `I2ST_IDX_TIMEOUT, 32'h4);
        repeat (10) @(posedge clk);
        apb(1'h1, `I2ST_IDX_TIMEOUT, 32'h0);
        apb(1'h1, `I2ST_IDX_TIMEOUT, 32'h4);
        repeat (10) @(posedge clk);
        check("to_restart", 32'(irq), 32'h0);
        apb(1'h1, `I2ST_IDX_TIMEOUT, 32'h0);
        engIn.byteActive <= 1'h1;
        makeStart <= 1'h1;
        @(posedge clk);
        makeStart <= 1'h0;
        repeat (10) @(posedge clk);
        engIn.byteActive <= 1'h0;
        check("buserr_flag", 32'(engOut.serialEvent), 32'h1);
        rchk("buserr_code", `I2ST_IDX_STATE, 32'h0);
        apb(1'h0, `I2ST_IDX_INTSTAT, 32'h0);
        check("buserr_stat", 32'(rd[2]), 32'h1);
        clear_all();
        report_and_stop();
    end
endmodule : i2st_top_test
